/* inc/gpmc_regs.vh */
// Purpose: constants for the gauge power-mode control block
// Assumes: 125 MHz clock, 8 ns period
// Notes: times in their own unit, cycle counts derived
// Function
// R01 - After power-up the block starts in the active state.
// R02 - Active state keeps measurement and estimation running continuously.
// R03 - Sleep halts measurement and estimation; stored values are kept.
// R04 - Two sleep conditions, each with its own enable bit.
// R05 - Disconnect sleep: enable set and data line low for the timeout.
// R06 - Disconnect sleep ends when the data line goes high.
// R07 - Undervoltage sleep: enable, cell below threshold, line quiet for timeout.
// R08 - Undervoltage sleep ends when line activity resumes.
// R09 - Master pulls line high, then resets, to wake from disconnect sleep.
// R10 - Undervoltage sleep from high line accepts reset at once.
// R11 - No presence pulse on first rising edge after a low-line sleep.
// R12 - System disables both sleep options on chargers ignoring the line.
// R13 - Speed-select high picks overdrive timing, low picks standard timing.
// R14 - All multidrop devices run at the same bus speed.
// R15 - Bus rates are 16 kbps standard and 140 kbps overdrive.
// R16 - Divider enable rises before conversion, falls when cycle ends.
// R17 - Programmable pin is input or open-drain; input rise enables display.
// R18 - Fixed 64-bit identity: family code, serial number, CRC.
// R19 - Sixteen bytes of user nonvolatile memory for the host.
// R20 - Quiet counter restarts on every data line level change.
`ifndef GPMC_REGS_VH
`define GPMC_REGS_VH
`define GPMC_CLK_MHZ 125
`define GPMC_SLEEP_MS 2000
// Sized to the counter: 2000 ms at 125 cycles per microsecond
`define GPMC_SLEEP_CYC 28'd250000000
`define GPMC_CNT_W 28
`define GPMC_STD_KBPS 16
`define GPMC_OVD_KBPS 140
// Clock cycles per bit: 125000 / 16 and 125000 / 140, truncated
`define GPMC_STD_BIT_CYC 16'd7812
`define GPMC_OVD_BIT_CYC 16'd892
`define GPMC_BIT_W 16
`define GPMC_PIN_N 4
`define GPMC_SYNC_N 3
`define GPMC_SYNC_RST 3'h0
`define GPMC_PIN_DQ 0
`define GPMC_PIN_SPD 1
`define GPMC_PIN_UV 2
`define GPMC_PIN_PIO 3
`define GPMC_ID_W 64
`define GPMC_USER_BYTES 16
`define GPMC_USER_AW 4
`endif

/* design/gpmc_top.v */
// Purpose: power-mode and pin control of a cell fuel gauge
// Assumes: single clock; pins synchronised here
// Notes: measurement datapath lives outside; this block gates it
`timescale 1ns/1ps
`include "gpmc_regs.vh"
module gpmc_top #(
  parameter [`GPMC_CNT_W-1:0] SLEEP_CYC = `GPMC_SLEEP_CYC,
  parameter [`GPMC_ID_W-1:0] ID_CODE = 64'h0123_4567_89ab_cd01 // Arbitrary value
) (
  input wire clk_in,
  input wire rst_b_in,
  input wire data_line_in,
  input wire disconnect_sleep_enable_in,
  input wire undervoltage_sleep_enable_in,
  input wire cell_below_threshold_in,
  input wire speed_select_input_in,
  input wire conv_request_in,
  input wire conv_done_in,
  input wire pio_out_mode_in,
  input wire pio_drive_low_in,
  input wire pio_in,
  input wire presence_req_in,
  input wire user_we_in,
  input wire [`GPMC_USER_AW-1:0] user_addr_in,
  input wire [7:0] user_wdata_in,
  output reg active_out,
  output reg measure_enable_out,
  output reg conv_start_out,
  output reg divider_enable_output_out,
  output reg overdrive_out,
  output reg [`GPMC_BIT_W-1:0] bit_period_out,
  output reg display_enable_out,
  output reg pio_oe_out,
  output reg pio_o_out,
  output reg presence_allow_out,
  output reg [`GPMC_ID_W-1:0] id_out,
  output reg [7:0] user_rdata_out
);
  localparam [2:0] ST_ACTIVE = 3'b001;
  localparam [2:0] ST_DSLEEP = 3'b010;
  localparam [2:0] ST_USLEEP = 3'b100;
  localparam [`GPMC_BIT_W-1:0] BIT_STD = `GPMC_STD_BIT_CYC;
  localparam [`GPMC_BIT_W-1:0] BIT_OVD = `GPMC_OVD_BIT_CYC;

  reg rst_s1_r;
  reg rst_s2_r;
  wire rst_b;

  wire [`GPMC_PIN_N-1:0] pin_raw;
  wire [`GPMC_PIN_N-1:0] pin_lvl;
  wire [`GPMC_PIN_N-1:0] pin_rise;
  wire [`GPMC_PIN_N-1:0] pin_fall;
  wire dq_lvl;
  wire dq_chg;
  wire spd_lvl;
  wire uv_lvl;
  wire pio_chg;

  wire go_disc;
  wire go_uv;
  wire sleep_entry;
  wire conv_take;
  wire presence_ok;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [`GPMC_CNT_W-1:0] quiet_r;
  reg quiet_done_r;
  reg usleep_high_r;
  reg skip_edge_r;
  reg conv_busy_r;
  reg conv_pend_r;
  reg [7:0] user_mem_r [0:`GPMC_USER_BYTES-1];

  // Agreement of two late stages filters single-sample glitches
  function stable_hi;
    input [2:0] s;
    begin
      stable_hi = s[1] & s[2];
    end
  endfunction

  function stable_lo;
    input [2:0] s;
    begin
      stable_lo = ~s[1] & ~s[2];
    end
  endfunction

  function is_active;
    input [2:0] st;
    begin
      is_active = (st == ST_ACTIVE);
    end
  endfunction

  function [`GPMC_BIT_W-1:0] bit_cycles;
    input fast;
    begin
      bit_cycles = fast ? BIT_OVD : BIT_STD; // see R15
    end
  endfunction

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      rst_s1_r <= 1'b0;
    else
      rst_s1_r <= 1'b1;
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      rst_s2_r <= 1'b0;
    else
      rst_s2_r <= rst_s1_r;
  end
  assign rst_b = rst_s2_r;

  // Three stages per pin; a level is taken once the two late stages agree
  assign pin_raw = {pio_in, cell_below_threshold_in, speed_select_input_in, data_line_in};

  genvar g;
  generate
    for (g = 0; g < `GPMC_PIN_N; g = g + 1) begin : g_pin
      reg [`GPMC_SYNC_N-1:0] stage_r;
      reg level_r;
      always @(posedge clk_in or negedge rst_b) begin
        if (!rst_b) begin
          stage_r <= `GPMC_SYNC_RST;
          level_r <= 1'b0;
        end else begin
          stage_r <= {stage_r[`GPMC_SYNC_N-2:0], pin_raw[g]};
          if (stable_hi(stage_r) | stable_lo(stage_r))
            level_r <= stage_r[`GPMC_SYNC_N-1];
        end
      end
      assign pin_lvl[g] = level_r;
      assign pin_rise[g] = stable_hi(stage_r) & ~level_r;
      assign pin_fall[g] = stable_lo(stage_r) & level_r;
    end
  endgenerate

  assign dq_lvl = pin_lvl[`GPMC_PIN_DQ];
  assign dq_chg = pin_rise[`GPMC_PIN_DQ] | pin_fall[`GPMC_PIN_DQ];
  assign spd_lvl = pin_lvl[`GPMC_PIN_SPD];
  assign uv_lvl = pin_lvl[`GPMC_PIN_UV];
  assign pio_chg = pin_rise[`GPMC_PIN_PIO];

  assign go_disc = disconnect_sleep_enable_in & quiet_done_r & ~dq_lvl & ~dq_chg;
  assign go_uv = undervoltage_sleep_enable_in & uv_lvl & quiet_done_r & ~dq_chg;
  assign sleep_entry = is_active(state_r) & ~is_active(state_nxt);
  assign conv_take = ~conv_busy_r & conv_request_in & is_active(state_r);
  assign presence_ok = ~(skip_edge_r & ~usleep_high_r);

  // Quiet timer; any level change restarts it
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b)
      quiet_r <= {`GPMC_CNT_W{1'b0}};
    else if (dq_chg)
      quiet_r <= {`GPMC_CNT_W{1'b0}}; // see R20
    else if (quiet_r < SLEEP_CYC - 1'b1)
      quiet_r <= quiet_r + 1'b1;
  end

  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b)
      quiet_done_r <= 1'b0;
    else
      quiet_done_r <= ~dq_chg & (quiet_r >= SLEEP_CYC - 1'b1);
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_ACTIVE: begin
        // Both enables clear keeps the block awake forever; see R04
        if (go_disc)
          state_nxt = ST_DSLEEP; // see R05
        else if (go_uv)
          state_nxt = ST_USLEEP; // see R07
      end
      ST_DSLEEP: begin
        if (dq_chg & ~dq_lvl)
          state_nxt = ST_ACTIVE; // see R06
      end
      ST_USLEEP: begin
        if (dq_chg)
          state_nxt = ST_ACTIVE; // see R08
      end
      default: state_nxt = ST_ACTIVE;
    endcase
  end

  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b)
      state_r <= ST_ACTIVE; // see R01
    else
      state_r <= state_nxt;
  end

  // Line level at sleep entry decides whether the wake edge is swallowed
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b)
      usleep_high_r <= 1'b0;
    else if (sleep_entry)
      usleep_high_r <= dq_lvl; // see R10
  end

  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b)
      skip_edge_r <= 1'b0;
    else if (sleep_entry)
      skip_edge_r <= ~dq_lvl; // see R11
    else if (is_active(state_r) && presence_req_in)
      skip_edge_r <= 1'b0;
  end

  // Divider goes up a cycle ahead of the start so the input settles
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      conv_busy_r <= 1'b0;
      divider_enable_output_out <= 1'b0;
    end else if (conv_take) begin
      conv_busy_r <= 1'b1;
      divider_enable_output_out <= 1'b1; // see R16
    end else if (conv_pend_r && !is_active(state_nxt)) begin
      conv_busy_r <= 1'b0;
      divider_enable_output_out <= 1'b0;
    end else if (conv_busy_r && !conv_pend_r && conv_done_in) begin
      conv_busy_r <= 1'b0;
      divider_enable_output_out <= 1'b0; // see R16
    end
  end

  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b)
      conv_pend_r <= 1'b0;
    else
      conv_pend_r <= conv_take;
  end

  // A start that meets sleep entry is dropped, and the divider with it; see R03
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b)
      conv_start_out <= 1'b0;
    else
      conv_start_out <= conv_pend_r & is_active(state_nxt);
  end

  always @(posedge clk_in) begin
    if (user_we_in)
      user_mem_r[user_addr_in] <= user_wdata_in; // see R19
  end

  // Every output leaves from a flip-flop
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      active_out <= 1'b1;
    end else begin
      active_out <= is_active(state_nxt);
    end
  end

  // Register contents live outside and simply stop updating; see R02 R03
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      measure_enable_out <= 1'b0;
    end else begin
      measure_enable_out <= is_active(state_nxt);
    end
  end

  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      overdrive_out <= 1'b0;
    end else begin
      overdrive_out <= spd_lvl; // see R13
    end
  end

  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      bit_period_out <= {`GPMC_BIT_W{1'b0}};
    end else begin
      bit_period_out <= bit_cycles(spd_lvl); // see R15
    end
  end

  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      display_enable_out <= 1'b0;
    end else begin
      display_enable_out <= ~pio_out_mode_in & pio_chg; // see R17
    end
  end

  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      pio_oe_out <= 1'b0;
    end else begin
      pio_oe_out <= pio_out_mode_in & pio_drive_low_in; // see R17
    end
  end

  // Open drain: the pin is only ever pulled low
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      pio_o_out <= 1'b0;
    end else begin
      pio_o_out <= 1'b0;
    end
  end

  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      presence_allow_out <= 1'b0;
    end else begin
      presence_allow_out <= is_active(state_r) & presence_req_in & presence_ok; // see R11
    end
  end

  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      id_out <= {`GPMC_ID_W{1'b0}};
    end else begin
      id_out <= ID_CODE; // see R18
    end
  end

  // Read data trails the address by one cycle
  always @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      user_rdata_out <= 8'h00;
    end else begin
      user_rdata_out <= user_mem_r[user_addr_in];
    end
  end
endmodule

/* bench/gpmc_master.sv */
// Purpose: bus master that drives the data line
// Assumes: weak pulldown pulls a released line low
// Notes: mode 0 release, 1 drive high, 2 pull high then reset pulse
`timescale 1ns/1ps
module gpmc_master (
  input wire clk_in,
  input wire [1:0] mode_in,
  output logic line_out
);
  logic [7:0] cnt_r = 8'h00;
  always @(posedge clk_in) begin
    cnt_r <= (mode_in == 2'h2) ? cnt_r + 8'h01 : 8'h00;
    case (mode_in)
      2'h0: line_out <= 1'b0;
      2'h1: line_out <= 1'b1;
      default: line_out <= (cnt_r >= 8'h10 && cnt_r < 8'h50) ? 1'b0 : 1'b1;
    endcase
  end
endmodule

/* bench/gpmc_monitor.sv */
// Purpose: port assertions for gauge power-mode control
// Assumes: one clock, reset active low
// Notes: quiet counter restarts on any data line change
`timescale 1ns/1ps
module gpmc_monitor #(parameter [27:0] SLEEP_CYC = 28'd200) (
  input wire clk_in,
  input wire rst_b_in,
  input wire data_line_in,
  input wire disconnect_sleep_enable_in,
  input wire undervoltage_sleep_enable_in,
  input wire conv_done_in,
  input wire active_out,
  input wire measure_enable_out,
  input wire conv_start_out,
  input wire divider_enable_output_out,
  input wire overdrive_out,
  input wire [15:0] bit_period_out,
  input wire display_enable_out,
  input wire pio_o_out
);
  logic [31:0] quiet_r;
  logic line_r;
  wire en_any_w = disconnect_sleep_enable_in | undervoltage_sleep_enable_in;
  always @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in) begin
      quiet_r <= 32'h0;
      line_r <= 1'b0;
    end else begin
      line_r <= data_line_in;
      quiet_r <= (data_line_in != line_r) ? 32'h0 : quiet_r + 32'h1;
    end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence div_close_s;
    divider_enable_output_out && conv_done_in ##1 !divider_enable_output_out;
  endsequence
  sequence div_open_s;
    $rose(divider_enable_output_out) ##1 (conv_start_out || !active_out);
  endsequence
  div_lead_a: assert property ($rose(divider_enable_output_out) |-> div_open_s)
    else $error("conversion start did not follow divider rise");
  conv_start_a: assert property (conv_start_out |-> divider_enable_output_out && active_out)
    else $error("conversion start without divider or while asleep");
  div_drop_a: assert property (divider_enable_output_out && conv_done_in |-> div_close_s)
    else $error("divider stayed high after conversion end");
  sleep_halt_a: assert property (!active_out |-> !measure_enable_out)
    else $error("measurement running in sleep");
  run_meas_a: assert property (active_out [*8] |-> measure_enable_out)
    else $error("measurement idle while active");
  sleep_quiet_a: assert property ($fell(active_out) |-> quiet_r >= SLEEP_CYC)
    else $error("sleep entered before quiet timeout");
  sleep_gate_a: assert property ($fell(active_out) |-> $past(en_any_w))
    else $error("sleep entered with both enables clear");
  wake_a: assert property (!active_out && $changed(data_line_in) |-> ##[1:8] active_out)
    else $error("no wake after line change");
  speed_hi_a: assert property ($rose(overdrive_out) |-> ##[0:2] bit_period_out == 16'd892)
    else $error("wrong overdrive bit period");
  disp_pulse_a: assert property (display_enable_out |=> !display_enable_out)
    else $error("display enable longer than one cycle");
  pio_od_a: assert property (!pio_o_out)
    else $error("programmable pin driven high");
endmodule
bind gpmc_top gpmc_monitor #(.SLEEP_CYC(SLEEP_CYC)) mon (.*);

/* bench/tb_gauge_power_mode_control.sv */
// Purpose: self-checking bench for gauge power-mode control
// Assumes: sleep timeout shortened to 200 cycles
// Notes: watcher pops one note per change of the status vector
`timescale 1ns/1ps
module tb_gauge_power_mode_control;
  logic clk_in = 1'b0, rst_b_in = 1'b0, dsl = 1'b0, usl = 1'b0, cbt = 1'b0, spd = 1'b0;
  logic creq = 1'b0, cdone = 1'b0, pmode = 1'b0, programmable_io_pin = 1'b0, pres = 1'b0, watch = 1'b0;
  logic [1:0] mode = 2'h0;
  logic pdl = 1'b0, we = 1'b0;
  logic [3:0] ua = 4'h0;
  logic [7:0] ud = 8'h00;
  wire [7:0] urd;
  wire [63:0] idv;
  logic [17:0] q[$];
  logic [17:0] last;
  logic [31:0] rs = 32'd82;
  int mismatches = 0, n_compared = 0, npal = 0;
  wire line, act, div, disp, oe, pal;
  wire [15:0] bp;
  gpmc_master mst (.clk_in(clk_in), .mode_in(mode), .line_out(line));
  gpmc_top #(.SLEEP_CYC(28'd200), .ID_CODE(64'h5a5a_0f0f_3c3c_9696)) dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .data_line_in(line),
    .disconnect_sleep_enable_in(dsl), .undervoltage_sleep_enable_in(usl), .cell_below_threshold_in(cbt),
    .speed_select_input_in(spd), .conv_request_in(creq), .conv_done_in(cdone), .pio_out_mode_in(pmode),
    .pio_drive_low_in(pdl), .pio_in(programmable_io_pin), .presence_req_in(pres), .user_we_in(we), .user_addr_in(ua),
    .user_wdata_in(ud), .active_out(act), .measure_enable_out(), .conv_start_out(),
    .divider_enable_output_out(div), .overdrive_out(), .bit_period_out(bp), .display_enable_out(disp),
    .pio_oe_out(oe), .pio_o_out(), .presence_allow_out(pal), .id_out(idv), .user_rdata_out(urd));
  initial forever #4 clk_in = ~clk_in;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic w(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_in) if (pal) npal++;
  always @(negedge clk_in) if (watch && {disp, act, bp} !== last) begin
    last = {disp, act, bp};
    chk(last, q.size() ? q.pop_front() : 18'h3ffff);
  end
  initial begin
    w(20000);
    mismatches++;
    complete_run;
  end
  initial begin
    w(8);
    rst_b_in = 1'b1;
    w(30);
    chk({1'b0, act, bp}, {2'b01, 16'd7812});
    rs = xs(rs);
    ua = rs[3:0];
    ud = rs[11:4];
    we = 1'b1;
    w(1);
    we = 1'b0;
    w(1);
    chk({10'd0, urd}, {10'd0, ud});
    chk(18'(idv == 64'h5a5a_0f0f_3c3c_9696), 18'd1);
    last = {disp, act, bp};
    watch = 1'b1;
    spd = 1'b1;
    q.push_back({2'b01, 16'd892});
    w(20);
    spd = 1'b0;
    q.push_back({2'b01, 16'd7812});
    w(20);
    creq = 1'b1;
    w(1);
    creq = 1'b0;
    chk({17'd0, div}, 18'd1);
    w(5);
    cdone = 1'b1;
    w(1);
    cdone = 1'b0;
    w(1);
    chk({17'd0, div}, 18'd0);
    w(400); // Both enables clear, line low: no sleep
    mode = 2'h1;
    w(10);
    dsl = 1'b1;
    mode = 2'h0;
    q.push_back({2'b00, 16'd7812});
    for (int i = 0; i < 3; i++) begin
      rs = xs(rs);
      w(50 + int'(rs % 120));
      mode = 2'h1;
      w(4);
      mode = 2'h0;
    end
    w(260);
    creq = 1'b1; // Refused while asleep
    w(1);
    creq = 1'b0;
    w(2);
    chk({17'd0, div}, 18'd0);
    q.push_back({2'b01, 16'd7812});
    mode = 2'h2;
    w(120);
    mode = 2'h1;
    for (int i = 0; i < 2; i++) begin
      pres = 1'b1;
      w(1);
      pres = 1'b0;
      w(5);
    end
    chk(18'(npal), 18'd1);
    dsl = 1'b0;
    usl = 1'b1;
    cbt = 1'b1;
    q.push_back({2'b00, 16'd7812});
    q.push_back({2'b01, 16'd7812});
    w(260);
    mode = 2'h0;
    w(20);
    q.push_back({2'b11, 16'd7812});
    q.push_back({2'b01, 16'd7812});
    programmable_io_pin = 1'b1;
    w(10);
    pmode = 1'b1;
    w(6);
    chk({17'd0, oe}, 18'd0);
    pdl = 1'b1;
    w(2);
    chk({17'd0, oe}, 18'd1);
    chk(18'(q.size()), 18'd0);
    complete_run;
  end
endmodule
